//--- src/exec_ops_pkg.sv
package exec_ops_pkg;

	// register byte offsets on the bus
	localparam logic [7:0] OFF_ACC = 8'h00;
	localparam logic [7:0] OFF_STATUS = 8'h04;
	localparam logic [7:0] OFF_MEM = 8'h08;
	localparam logic [7:0] OFF_IMM = 8'h0c;
	localparam logic [7:0] OFF_TPTR = 8'h10;
	localparam logic [7:0] OFF_THIGH = 8'h14;
	localparam logic [7:0] OFF_PAGE = 8'h18;
	localparam logic [7:0] OFF_CMD = 8'h1c;
	localparam logic [7:0] OFF_INFO = 8'h20;

	// field layout
	localparam int CMD_OP_LSB = 0;
	localparam int CMD_OP_W = 5;
	localparam int CMD_BIT_LSB = 5;
	localparam int CMD_BIT_W = 3;
	localparam int INFO_BUSY = 0;
	localparam int INFO_SKIP = 1;
	localparam int PAGE_W = 3;
	localparam int NIB_W = 4;

	// reset values and constants
	localparam logic [7:0] BYTE_ZERO = 8'h00;
	localparam logic [7:0] BYTE_ONES = 8'hff;
	localparam logic [7:0] BYTE_ONE = 8'h01;
	localparam logic [PAGE_W-1:0] PAGE_RESET = 3'h0;
	localparam logic [PAGE_W-1:0] PAGE_LAST = 3'h7;
	localparam logic [31:0] WORD_ZERO = 32'h0000_0000;

	// status flags, borrow_out_bit in bit 0
	typedef struct packed {
		logic signed_flow_bit;
		logic null_result_bit;
		logic half_borrow_bit;
		logic borrow_out_bit;
	} flags_s;

	localparam flags_s FLAGS_RESET = '{1'b0, 1'b0, 1'b0, 1'b0};

	// operation codes
	typedef enum logic [CMD_OP_W-1:0] {
		OP_NOP = 5'h00,
		OP_ROTATE_RIGHT_CARRY_TO_ACC = 5'h01,
		OP_SUB_WITH_BORROW = 5'h02,
		OP_SUB_WITH_BORROW_TO_MEM = 5'h03,
		OP_MINUS_MEM = 5'h04,
		OP_MINUS_TO_MEM = 5'h05,
		OP_MINUS_IMM = 5'h06,
		OP_DEC_SKIP_ZERO = 5'h07,
		OP_DEC_SKIP_ZERO_TO_ACC = 5'h08,
		OP_INC_SKIP_ZERO = 5'h09,
		OP_INC_SKIP_ZERO_TO_ACC = 5'h0a,
		OP_BIT_SET_SKIP = 5'h0b,
		OP_ZERO_TEST_SKIP = 5'h0c,
		OP_COPY_ZERO_TEST_SKIP = 5'h0d,
		OP_ZERO_TEST_SKIP_BIT = 5'h0e,
		OP_BYTE_SET = 5'h0f,
		OP_BIT_SET = 5'h10,
		OP_NIBBLE_EXCHANGE = 5'h11,
		OP_NIBBLE_EXCHANGE_TO_ACC = 5'h12,
		OP_TABLE_READ_CURRENT_PAGE = 5'h13,
		OP_TABLE_READ_FINAL_PAGE = 5'h14,
		OP_EXCLUSIVE_OR = 5'h15,
		OP_EXCLUSIVE_OR_TO_MEM = 5'h16,
		OP_EXCLUSIVE_OR_IMM = 5'h17
	} op_e;

	// machine cycle sequencer states
	typedef enum logic [3:0] {
		ST_IDLE = 4'b0001,
		ST_EXEC = 4'b0010,
		ST_TABLE = 4'b0100,
		ST_DUMMY = 4'b1000
	} state_e;

	// arithmetic result with its flags
	typedef struct packed {
		logic [7:0] value;
		flags_s flags;
	} alu_s;

endpackage

//--- src/exec_ops.sv
// Overview of operation
// - rotate right through borrow into accumulator
// - subtract with borrow, to acc or mem
// - memory subtract plus one, all flags
// - immediate subtract into accumulator, all flags
// - met skip discards prefetch, adds dummy
// - decrement memory, skip on zero
// - decrement into accumulator, skip on zero
// - increment memory, skip on wrap
// - increment into accumulator, skip on zero
// - skip when selected bit is one
// - skip when memory byte is zero
// - copy memory to acc, skip if zero
// - skip when selected bit is zero
// - byte set writes all ones
// - bit set forces one selected bit
// - swap memory nibbles in place
// - swapped memory nibbles into accumulator
// - table read from current page
// - table read from final page
// - xor memory into accumulator, zero only
// - xor result into memory, zero only
// - xor immediate into accumulator, zero only
//
// Implementation choices: register access over Wishbone and the placing of the registers.
module exec_ops
	import exec_ops_pkg::*;
(
	input wire logic clk_i,
	input wire logic reset_i,
	input wire logic wb_cyc_i,
	input wire logic wb_stb_i,
	input wire logic wb_we_i,
	input wire logic [7:0] wb_adr_i,
	input wire logic [3:0] wb_sel_i,
	input wire logic [31:0] wb_dat_i,
	output logic [31:0] wb_dat_o,
	output logic wb_ack_o,
	output logic [10:0] rom_addr_o,
	input wire logic [15:0] rom_data_i,
	output logic discard_o,
	output logic busy_o
);

	// mask with one bit set at the selected position
	function automatic logic [7:0] bit_mask(input logic [CMD_BIT_W-1:0] idx);
		bit_mask = BYTE_ONE << idx;
	endfunction

	// zero test shared by the skips and the null flag
	function automatic logic is_zero(input logic [7:0] v);
		is_zero = (v == BYTE_ZERO);
	endfunction

	// the two table reads need the extra program rom cycle
	function automatic logic is_table_op(input op_e o);
		is_table_op = (o == OP_TABLE_READ_CURRENT_PAGE) ||
			(o == OP_TABLE_READ_FINAL_PAGE);
	endfunction

	// subtract core: a + ~b + cin with flag extraction
	function automatic alu_s subtract(input logic [7:0] a, input logic [7:0] b,
			input logic cin);
		logic [8:0] full;
		logic [4:0] low;
		logic [7:0] nb;
		nb = ~b;
		full = {1'b0, a} + {1'b0, nb} + {8'h00, cin};
		low = {1'b0, a[3:0]} + {1'b0, nb[3:0]} + {4'h0, cin};
		subtract.value = full[7:0];
		subtract.flags.borrow_out_bit = full[8];
		subtract.flags.half_borrow_bit = low[NIB_W];
		subtract.flags.signed_flow_bit = (a[7] == nb[7]) && (full[7] != a[7]);
		subtract.flags.null_result_bit = is_zero(full[7:0]);
	endfunction

	state_e state;
	state_e next_state;
	logic [7:0] acc;
	logic [7:0] next_acc;
	logic [7:0] mem;
	logic [7:0] next_mem;
	logic [7:0] imm;
	logic [7:0] tptr;
	logic [7:0] thigh;
	logic [PAGE_W-1:0] page;
	flags_s flags;
	flags_s next_flags;
	op_e op;
	logic [CMD_BIT_W-1:0] bit_idx;
	logic skip_flag;
	logic next_skip;
	logic [31:0] read_word;

	// bus decode: writes land on the ack edge
	// while an instruction runs they are acked but dropped
	wire logic bus_req = wb_cyc_i && wb_stb_i;
	wire logic wr_take = bus_req && wb_ack_o && wb_we_i && wb_sel_i[0] && !busy_o;
	wire logic wr_acc = wr_take && (wb_adr_i == OFF_ACC);
	wire logic wr_status = wr_take && (wb_adr_i == OFF_STATUS);
	wire logic wr_mem = wr_take && (wb_adr_i == OFF_MEM);
	wire logic wr_imm = wr_take && (wb_adr_i == OFF_IMM);
	wire logic wr_tptr = wr_take && (wb_adr_i == OFF_TPTR);
	wire logic wr_page = wr_take && (wb_adr_i == OFF_PAGE);
	wire logic wr_cmd = wr_take && (wb_adr_i == OFF_CMD);

	// operand views
	wire logic [7:0] mask = bit_mask(bit_idx);
	// per-bit match at the selected position, reduced to one skip bit
	logic [7:0] bit_hit;
	for (genvar i = 0; i < $bits(bit_hit); i++) begin : g_bit_hit
		assign bit_hit[i] = mask[i] && mem[i];
	end
	wire logic sel_bit = |bit_hit;
	wire logic [7:0] mem_dec = mem - BYTE_ONE;
	wire logic [7:0] mem_inc = mem + BYTE_ONE;
	wire logic [7:0] mem_swap = {mem[NIB_W-1:0], mem[7:NIB_W]};
	wire logic [7:0] mem_xor = acc ^ mem;
	wire logic [7:0] imm_xor = acc ^ imm;
	// acc plus inverted memory plus borrow
	wire alu_s sub_borrow = subtract(acc, mem, flags.borrow_out_bit);
	// acc plus inverted memory plus one
	wire alu_s sub_mem = subtract(acc, mem, 1'b1);
	// acc plus inverted immediate plus one
	wire alu_s sub_imm = subtract(acc, imm, 1'b1);
	wire logic [PAGE_W-1:0] table_page =
		(op == OP_TABLE_READ_FINAL_PAGE) ? PAGE_LAST : page;

	// read multiplexer
	always_comb begin
		read_word = WORD_ZERO;
		case (wb_adr_i)
			OFF_ACC: read_word[7:0] = acc;
			OFF_STATUS: read_word[3:0] = flags;
			OFF_MEM: read_word[7:0] = mem;
			OFF_IMM: read_word[7:0] = imm;
			OFF_TPTR: read_word[7:0] = tptr;
			OFF_THIGH: read_word[7:0] = thigh;
			OFF_PAGE: read_word[PAGE_W-1:0] = page;
			OFF_CMD: read_word[7:0] = {bit_idx, op};
			OFF_INFO: read_word[1:0] = {skip_flag, busy_o};
			default: read_word = WORD_ZERO;
		endcase
	end

	// execute datapath for one machine cycle
	always_comb begin
		next_acc = acc;
		next_mem = mem;
		next_flags = flags;
		next_skip = 1'b0;
		case (op)
			OP_ROTATE_RIGHT_CARRY_TO_ACC: begin
				next_acc = {flags.borrow_out_bit, mem[7:1]};
				next_flags.borrow_out_bit = mem[0];
			end
			OP_SUB_WITH_BORROW: begin
				next_acc = sub_borrow.value;
				next_flags = sub_borrow.flags;
			end
			OP_SUB_WITH_BORROW_TO_MEM: begin
				next_mem = sub_borrow.value;
				next_flags = sub_borrow.flags;
			end
			OP_MINUS_MEM: begin
				next_acc = sub_mem.value;
				next_flags = sub_mem.flags;
			end
			OP_MINUS_TO_MEM: begin
				next_mem = sub_mem.value;
				next_flags = sub_mem.flags;
			end
			OP_MINUS_IMM: begin
				next_acc = sub_imm.value;
				next_flags = sub_imm.flags;
			end
			OP_DEC_SKIP_ZERO: begin
				next_mem = mem_dec;
				next_skip = is_zero(mem_dec);
			end
			OP_DEC_SKIP_ZERO_TO_ACC: begin
				next_acc = mem_dec;
				next_skip = is_zero(mem_dec);
			end
			OP_INC_SKIP_ZERO: begin
				next_mem = mem_inc;
				next_skip = is_zero(mem_inc);
			end
			OP_INC_SKIP_ZERO_TO_ACC: begin
				next_acc = mem_inc;
				next_skip = is_zero(mem_inc);
			end
			OP_BIT_SET_SKIP: next_skip = sel_bit;
			OP_ZERO_TEST_SKIP: next_skip = is_zero(mem);
			OP_COPY_ZERO_TEST_SKIP: begin
				next_acc = mem;
				next_skip = is_zero(mem);
			end
			OP_ZERO_TEST_SKIP_BIT: next_skip = !sel_bit;
			OP_BYTE_SET: next_mem = BYTE_ONES;
			OP_BIT_SET: next_mem = mem | mask;
			OP_NIBBLE_EXCHANGE: next_mem = mem_swap;
			OP_NIBBLE_EXCHANGE_TO_ACC: next_acc = mem_swap;
			OP_EXCLUSIVE_OR: begin
				next_acc = mem_xor;
				next_flags.null_result_bit = is_zero(mem_xor);
			end
			OP_EXCLUSIVE_OR_TO_MEM: begin
				next_mem = mem_xor;
				next_flags.null_result_bit = is_zero(mem_xor);
			end
			OP_EXCLUSIVE_OR_IMM: begin
				next_acc = imm_xor;
				next_flags.null_result_bit = is_zero(imm_xor);
			end
			default: next_skip = 1'b0;
		endcase
	end

	// sequencer next state
	always_comb begin
		next_state = state;
		case (state)
			ST_IDLE: if (wr_cmd) begin
				next_state = ST_EXEC;
			end
			ST_EXEC: begin
				if (is_table_op(op)) begin
					next_state = ST_TABLE;
				end else if (next_skip) begin
					next_state = ST_DUMMY;
				end else begin
					next_state = ST_IDLE;
				end
			end
			ST_TABLE: next_state = ST_IDLE;
			ST_DUMMY: next_state = ST_IDLE;
			default: next_state = ST_IDLE;
		endcase
	end

	// bus slave: ack one cycle after request, dropped after one
	always_ff @(posedge clk_i) begin
		if (reset_i) begin
			wb_ack_o <= 1'b0;
			wb_dat_o <= WORD_ZERO;
		end else begin
			wb_ack_o <= bus_req && !wb_ack_o;
			if (bus_req && !wb_ack_o) begin
				wb_dat_o <= read_word;
			end
		end
	end

	// sequencer and pipeline outputs
	always_ff @(posedge clk_i) begin
		if (reset_i) begin
			state <= ST_IDLE;
			busy_o <= 1'b0;
			discard_o <= 1'b0;
			skip_flag <= 1'b0;
		end else begin
			state <= next_state;
			busy_o <= (next_state != ST_IDLE);
			discard_o <= (state == ST_EXEC) && (next_state == ST_DUMMY);
			// skip flag keeps the outcome of the last instruction
			if (state == ST_EXEC) begin
				skip_flag <= next_skip;
			end
		end
	end

	// table address to program rom, moved only by a table read
	// other instructions leave it alone so the rom bus stays quiet
	always_ff @(posedge clk_i) begin
		if (reset_i) begin
			rom_addr_o <= '0;
		end else if (state == ST_EXEC && is_table_op(op)) begin
			rom_addr_o <= {table_page, tptr};
		end
	end

	// command register; a write here starts the instruction
	always_ff @(posedge clk_i) begin
		if (reset_i) begin
			op <= OP_NOP;
			bit_idx <= '0;
		end else if (wr_cmd) begin
			op <= op_e'(wb_dat_i[CMD_OP_LSB +: CMD_OP_W]);
			bit_idx <= wb_dat_i[CMD_BIT_LSB +: CMD_BIT_W];
		end
	end

	// operand registers: immediate, table pointer, page
	always_ff @(posedge clk_i) begin
		if (reset_i) begin
			imm <= BYTE_ZERO;
			tptr <= BYTE_ZERO;
			page <= PAGE_RESET;
		end else begin
			if (wr_imm) begin
				imm <= wb_dat_i[7:0];
			end
			if (wr_tptr) begin
				tptr <= wb_dat_i[7:0];
			end
			if (wr_page) begin
				page <= wb_dat_i[PAGE_W-1:0];
			end
		end
	end

	// accumulator: datapath result or a bus write while idle
	always_ff @(posedge clk_i) begin
		if (reset_i) begin
			acc <= BYTE_ZERO;
		end else if (state == ST_EXEC) begin
			acc <= next_acc;
		end else if (wr_acc) begin
			acc <= wb_dat_i[7:0];
		end
	end

	// memory operand: datapath result, table low byte or a bus write
	always_ff @(posedge clk_i) begin
		if (reset_i) begin
			mem <= BYTE_ZERO;
		end else if (state == ST_EXEC) begin
			mem <= next_mem;
		end else if (state == ST_TABLE) begin
			mem <= rom_data_i[7:0];
		end else if (wr_mem) begin
			mem <= wb_dat_i[7:0];
		end
	end

	// status flags: datapath result or a status write while idle
	always_ff @(posedge clk_i) begin
		if (reset_i) begin
			flags <= FLAGS_RESET;
		end else if (state == ST_EXEC) begin
			flags <= next_flags;
		end else if (wr_status) begin
			flags <= flags_s'(wb_dat_i[3:0]);
		end
	end

	// table high latch, loaded only by the table read cycle
	always_ff @(posedge clk_i) begin
		if (reset_i) begin
			thigh <= BYTE_ZERO;
		end else if (state == ST_TABLE) begin
			thigh <= rom_data_i[15:8];
		end
	end

endmodule // exec_ops

//--- verif/rom_model.sv
module rom_model (
	input wire logic [10:0] addr_i,
	output logic [15:0] data_o
);
	timeunit 1ns;
	timeprecision 1ns;
	// program word pattern derived from the address, read combinationally
	assign data_o = {addr_i[7:0] ^ 8'ha5, addr_i[10:8], addr_i[4:0]};
endmodule // rom_model

//--- verif/exec_ops_asserts.sv
module exec_ops_asserts
	import exec_ops_pkg::*;
(
	input wire logic clk_i,
	input wire logic reset_i,
	input wire logic wb_cyc_i,
	input wire logic wb_stb_i,
	input wire logic wb_we_i,
	input wire logic [7:0] wb_adr_i,
	input wire logic [3:0] wb_sel_i,
	input wire logic [31:0] wb_dat_i,
	input wire logic [31:0] wb_dat_o,
	input wire logic wb_ack_o,
	input wire logic [10:0] rom_addr_o,
	input wire logic [15:0] rom_data_i,
	input wire logic discard_o,
	input wire logic busy_o
);
	timeunit 1ns;
	timeprecision 1ns;
	default clocking dc @(posedge clk_i);
	endclocking
	default disable iff (reset_i);
	// bus handshake
	a_ack_latency: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o)
		else $error("ack late");
	a_ack_pulse: assert property (wb_ack_o |=> !wb_ack_o)
		else $error("ack too long");
	a_ack_cause: assert property (wb_ack_o |-> $past(wb_cyc_i && wb_stb_i))
		else $error("ack without request");
	// skip and dummy cycle
	a_discard_pulse: assert property (discard_o |=> !discard_o && !busy_o)
		else $error("dummy cycle too long");
	a_discard_busy: assert property (discard_o |-> busy_o && $past(busy_o))
		else $error("discard outside execution");
	a_busy_bound: assert property ($rose(busy_o) |-> ##[1:2] !busy_o)
		else $error("execution too long");
	a_start_clean: assert property ($rose(busy_o) |-> !discard_o)
		else $error("discard in first cycle");
	a_busy_cause: assert property ($rose(busy_o) |->
		$past(wb_ack_o && wb_we_i && wb_adr_i == OFF_CMD)) else $error("start without command");
	// program rom address
	a_rom_addr_hold: assert property (!busy_o |=> $stable(rom_addr_o))
		else $error("rom address moved while idle");
endmodule // exec_ops_asserts

bind exec_ops exec_ops_asserts exec_ops_asserts_inst (.clk_i(clk_i), .reset_i(reset_i),
	.wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i),
	.wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o),
	.rom_addr_o(rom_addr_o), .rom_data_i(rom_data_i), .discard_o(discard_o), .busy_o(busy_o));

//--- verif/test_mcu_execute_ops_subset.sv
module test_mcu_execute_ops_subset;
	timeunit 1ns;
	timeprecision 1ns;
	import exec_ops_pkg::*;
	logic clk_i = 1'b0;
	logic reset_i = 1'b1;
	logic cyc = 1'b0;
	logic stb = 1'b0;
	logic we = 1'b0;
	logic [7:0] adr = 8'h00;
	logic [3:0] sel = 4'h0;
	logic [31:0] dat = 32'h0, rd, rdat;
	logic ack, discard, busy;
	logic [10:0] rom_addr;
	logic [15:0] rom_data;
	logic [15:0] seed = 16'h0008;
	int n_errors = 0;
	int num_checks = 0;
	exec_ops exec_ops_inst (.clk_i(clk_i), .reset_i(reset_i), .wb_cyc_i(cyc), .wb_stb_i(stb),
		.wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(dat), .wb_dat_o(rd),
		.wb_ack_o(ack), .rom_addr_o(rom_addr), .rom_data_i(rom_data), .discard_o(discard),
		.busy_o(busy));
	rom_model rom_model_inst (.addr_i(rom_addr), .data_o(rom_data));
	// clock
	initial begin
		forever #50 clk_i = ~clk_i;
	end
	// lfsr step
	function automatic logic [7:0] rnd();
		seed = {seed[14:0], seed[15] ^ seed[13] ^ seed[12] ^ seed[10]};
		return seed[7:0];
	endfunction
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		num_checks++;
		if (got !== exp) begin
			n_errors++;
			$display("[FAIL] %0t got %h expected %h", $time, got, exp);
		end
	endtask
	// one classic bus cycle, held until ack
	task automatic wb(input logic w, input logic [7:0] a, input logic [7:0] d);
		@(posedge clk_i);
		cyc <= 1'b1;
		stb <= 1'b1;
		we <= w;
		adr <= a;
		sel <= 4'hf;
		dat <= {24'h0, d};
		do @(posedge clk_i); while (ack !== 1'b1);
		rdat = rd;
		cyc <= 1'b0;
		stb <= 1'b0;
		we <= 1'b0;
	endtask
	task end_sim;
		if (n_errors == 0 && num_checks > 0) begin
			$display("bench passed");
		end else begin
			$display("bench failed");
		end
		$finish;
	endtask
	// expected result of one instruction
	function automatic void model(input op_e op, input logic [2:0] b, input logic [7:0] x,
		input logic [15:0] w, inout logic [7:0] a, inout logic [7:0] m, inout flags_s f,
		inout logic [7:0] th, output logic sk);
		logic [8:0] s;
		logic [4:0] h;
		logic [7:0] o;
		logic ci;
		o = (op == OP_MINUS_IMM) ? x : m;
		ci = (op == OP_SUB_WITH_BORROW || op == OP_SUB_WITH_BORROW_TO_MEM) ? f.borrow_out_bit : 1'b1;
		s = {1'b0, a} + {1'b0, ~o} + 9'(ci);
		h = {1'b0, a[3:0]} + {1'b0, ~o[3:0]} + 5'(ci);
		sk = 1'b0;
		case (op)
			OP_ROTATE_RIGHT_CARRY_TO_ACC: {a, f.borrow_out_bit} = {f.borrow_out_bit, m};
			OP_SUB_WITH_BORROW, OP_SUB_WITH_BORROW_TO_MEM, OP_MINUS_MEM, OP_MINUS_TO_MEM,
			OP_MINUS_IMM: begin
				f = '{(a[7] == ~o[7]) && (s[7] != a[7]), s[7:0] == 8'h00, h[4], s[8]};
				if (op == OP_SUB_WITH_BORROW_TO_MEM || op == OP_MINUS_TO_MEM) m = s[7:0];
				else a = s[7:0];
			end
			OP_DEC_SKIP_ZERO: {sk, m} = {m == 8'h01, m - 8'h01};
			OP_DEC_SKIP_ZERO_TO_ACC: {sk, a} = {m == 8'h01, m - 8'h01};
			OP_INC_SKIP_ZERO: {sk, m} = {m == 8'hff, m + 8'h01};
			OP_INC_SKIP_ZERO_TO_ACC: {sk, a} = {m == 8'hff, m + 8'h01};
			OP_BIT_SET_SKIP: sk = m[b];
			OP_ZERO_TEST_SKIP: sk = m == 8'h00;
			OP_COPY_ZERO_TEST_SKIP: {sk, a} = {m == 8'h00, m};
			OP_ZERO_TEST_SKIP_BIT: sk = !m[b];
			OP_BYTE_SET: m = 8'hff;
			OP_BIT_SET: m[b] = 1'b1;
			OP_NIBBLE_EXCHANGE: m = {m[3:0], m[7:4]};
			OP_NIBBLE_EXCHANGE_TO_ACC: a = {m[3:0], m[7:4]};
			OP_TABLE_READ_CURRENT_PAGE, OP_TABLE_READ_FINAL_PAGE: {th, m} = w;
			OP_EXCLUSIVE_OR: {f.null_result_bit, a} = {(a ^ m) == 8'h00, a ^ m};
			OP_EXCLUSIVE_OR_TO_MEM: {f.null_result_bit, m} = {(a ^ m) == 8'h00, a ^ m};
			OP_EXCLUSIVE_OR_IMM: {f.null_result_bit, a} = {(a ^ x) == 8'h00, a ^ x};
			default: ;
		endcase
	endfunction
	// watchdog
	initial begin
		repeat (20000) @(posedge clk_i);
		n_errors++;
		end_sim();
	end
	// main sequence
	initial begin
		logic [7:0] ea, em, x, tp, r, th;
		logic [2:0] pg, bx;
		logic [10:0] ra;
		flags_s ef;
		logic sk, tb;
		int n, nd;
		th = 8'h00;
		repeat (12) @(posedge clk_i);
		reset_i <= 1'b0;
		wb(1'b1, 8'h24, 8'hff);
		for (int k = 0; k < 10; k++) begin
			wb(1'b0, 8'(k * 4), 8'h00);
			chk(rdat, 32'h0);
		end
		for (int op = 0; op < 24; op++) begin
			for (int t = 0; t < 4; t++) begin
				ea = rnd();
				em = (t == 0) ? 8'h01 : (t == 1) ? 8'hff : (t == 2) ? 8'h00 : rnd();
				x = rnd();
				tp = rnd();
				r = rnd();
				ef = r[3:0];
				pg = r[6:4];
				bx = r[7:5];
				wb(1'b1, OFF_ACC, ea);
				wb(1'b1, OFF_STATUS, {4'h0, ef});
				wb(1'b1, OFF_MEM, em);
				wb(1'b1, OFF_IMM, x);
				wb(1'b1, OFF_TPTR, tp);
				wb(1'b1, OFF_PAGE, {5'h0, pg});
				tb = (op == OP_TABLE_READ_CURRENT_PAGE || op == OP_TABLE_READ_FINAL_PAGE);
				ra = {(op == OP_TABLE_READ_FINAL_PAGE) ? PAGE_LAST : pg, tp};
				model(op_e'(op), bx, x, {ra[7:0] ^ 8'ha5, ra[10:8], ra[4:0]}, ea, em, ef, th, sk);
				wb(1'b1, OFF_CMD, {bx, 5'(op)});
				#1;
				n = 0;
				nd = 0;
				while (busy === 1'b1 && n < 8) begin
					if (discard === 1'b1) nd++;
					n++;
					@(posedge clk_i);
					#1;
				end
				chk(32'(n), (sk || tb) ? 32'd2 : 32'd1);
				chk(32'(nd), {31'h0, sk});
				wb(1'b0, OFF_ACC, 8'h00);
				chk(rdat, {24'h0, ea});
				wb(1'b0, OFF_MEM, 8'h00);
				chk(rdat, {24'h0, em});
				wb(1'b0, OFF_STATUS, 8'h00);
				chk(rdat, {28'h0, ef});
				wb(1'b0, OFF_INFO, 8'h00);
				chk(rdat, {30'h0, sk, 1'b0});
				wb(1'b0, OFF_THIGH, 8'h00);
				chk(rdat, {24'h0, th});
			end
		end
		end_sim();
	end
endmodule // test_mcu_execute_ops_subset
